// *** design/sev_core.sv ***
`timescale 1ns/10ps
`include "sev_defs.svh"

// What this block does
// - A frame is a one start bit, two opcode bits, address, then data for writes.
// - Word mode frames are 13 bits with 10 address bits; byte mode 14 bits.
// - Opcode 11 clears only the addressed location.
// - Opcode 01 stores the following data, MSB first, at the address.
// - Opcode 00 uses top address bits: enable, disable, clear all, write all.
// - The top address bit is ignored but must be present in the frame.
// - Input bits are sampled on rising serial clock while chip select is high.
// - Output stays undriven except for read data and busy status.
// - After programming starts, selected device shows low while busy, high when ready.
// - A one clocked in during status releases the output on next falling edge.
// - Read drives one dummy zero, then the addressed word MSB first.
// - Read output bits change on each rising serial clock edge.
// - Continued clocking with chip select high streams the next word.
// - Sequential read wraps from the last location to location zero.
// - Only the first word of a sequential read has the dummy zero.
// - Organisation input high or open selects words, low selects bytes.
// - Programming starts only if select drops before the next clock after the frame.
// - Writes are disabled at power up until enabled; reads never blocked.
// - Clearing, single or whole array, leaves all affected bits at one.

module sev_core import sev_pkg::*; #(
   parameter int PROG_CYCLES = `SEV_PROG_TIME_MS * `SEV_SYS_CLK_KHZ
) (
   // System clock and reset.
   input wire logic sys_clk,
   input wire logic reset,
   // Serial link from the host.
   input wire logic serial_clock_in,
   input wire logic chip_select,
   input wire logic serial_data_in,
   // Organisation strap.
   input wire logic word_org_sel,
   // Three-state serial output.
   output logic serial_data_out,
   output logic serial_data_out_en
);

   localparam int TW = $clog2(PROG_CYCLES + 1);
   localparam int WORDS = 512;

   // The sweep of all locations must fit inside the programming time.
   if (PROG_CYCLES <= WORDS + 1) begin : g_prog_check
      $error("sev_core PROG_CYCLES too small for the array sweep");
   end

   // ---------------- Link clock domain ----------------

   logic frame_clr;
   logic org_k1_reg;
   logic org_k2_reg;
   logic [5:0] cnt_reg;
   logic [5:0] cnt_plus;
   logic [27:0] sh_reg;
   logic [27:0] sh_next;
   logic done_reg;
   logic taking;
   logic [5:0] frame_len;
   logic [5:0] data_len;
   logic [5:0] full_len;
   logic [1:0] hdr_op;
   logic [10:0] hdr_addr;
   logic [1:0] hdr_ext;
   logic hdr_needs_data;
   logic hdr_hit;
   logic full_hit;
   logic frame_end;
   logic rd_active_reg;
   logic [4:0] rd_left_reg;
   logic [15:0] rd_word_reg;
   logic [9:0] rd_addr_reg;
   logic [9:0] rd_wrap_mask;
   logic out_bit_reg;
   logic mute_reg;
   logic [8:0] rd_idx;
   logic [15:0] rd_data;
   logic [15:0] rd_sel;
   logic [1:0] cmd_op_reg;
   logic [10:0] cmd_addr_reg;
   logic [15:0] cmd_data_reg;
   logic cmd_need_reg;
   logic frame_ok_reg;

   // Chip select low empties the frame logic at once, without a clock edge.
   assign frame_clr = reset | ~chip_select;

   // Organisation strap synchroniser on the link clock; defaults to words.
   always_ff @(posedge serial_clock_in or posedge reset) begin
      if (reset) begin
         org_k1_reg <= 1'b1;
         org_k2_reg <= 1'b1;
      end else begin
         org_k1_reg <= word_org_sel;
         org_k2_reg <= org_k1_reg;
      end
   end

   // Frame geometry by organisation.
   always_comb begin
      frame_len = org_k2_reg ? `SEV_FRAME_WORD : `SEV_FRAME_BYTE;
      data_len = org_k2_reg ? `SEV_DLEN_WORD : `SEV_DLEN_BYTE;
      full_len = frame_len + data_len;
   end

   assign cnt_plus = cnt_reg + 6'h01;
   assign sh_next = {sh_reg[26:0], serial_data_in};
   assign taking = (cnt_reg != 6'h00) && !done_reg && !rd_active_reg;

   // Header fields as they stand once the last address bit arrives.
   always_comb begin
      if (org_k2_reg) begin
         hdr_op = sh_next[`SEV_W_OP_HI:`SEV_W_OP_LO];
         hdr_addr = {1'b0, sh_next[`SEV_W_ADDR_HI:0]};
         hdr_ext = sh_next[`SEV_W_EXT_HI:`SEV_W_EXT_LO];
      end else begin
         hdr_op = sh_next[`SEV_B_OP_HI:`SEV_B_OP_LO];
         hdr_addr = sh_next[`SEV_B_ADDR_HI:0];
         hdr_ext = sh_next[`SEV_B_EXT_HI:`SEV_B_EXT_LO];
      end
      hdr_needs_data = (hdr_op == `SEV_OP_WRITE) ||
                       ((hdr_op == `SEV_OP_EXT) && (hdr_ext == `SEV_EXT_WRALL));
   end

   // Frame completion points.
   assign hdr_hit = taking && (cnt_plus == frame_len);
   assign full_hit = taking && cmd_need_reg && (cnt_plus == full_len);
   assign frame_end = (hdr_hit && !hdr_needs_data && (hdr_op != `SEV_OP_READ)) || full_hit;

   // Bit counter and shifter; the start bit is a one after any leading zeros.
   always_ff @(posedge serial_clock_in or posedge frame_clr) begin
      if (frame_clr) begin
         cnt_reg <= 6'h00;
         sh_reg <= 28'h0000000;
         done_reg <= 1'b0;
      end else if (cnt_reg == 6'h00) begin
         if (serial_data_in) begin
            cnt_reg <= 6'h01;
         end
      end else if (taking) begin
         cnt_reg <= cnt_plus;
         sh_reg <= sh_next;
         if (frame_end) begin
            done_reg <= 1'b1;
         end
      end
   end

   // Command capture survives chip select low so the system side can act on it.
   always_ff @(posedge serial_clock_in or posedge reset) begin
      if (reset) begin
         cmd_op_reg <= 2'h0;
         cmd_addr_reg <= 11'h000;
         cmd_data_reg <= 16'h0000;
         cmd_need_reg <= 1'b0;
         frame_ok_reg <= 1'b0;
      end else if (chip_select) begin
         if (cnt_reg == 6'h00 && serial_data_in) begin
            frame_ok_reg <= 1'b0;
         end else if (done_reg) begin
            // A clock edge after the last bit spoils the frame.
            frame_ok_reg <= 1'b0;
         end else if (frame_end) begin
            frame_ok_reg <= 1'b1;
         end
         if (hdr_hit) begin
            cmd_op_reg <= hdr_op;
            cmd_addr_reg <= hdr_addr;
            cmd_need_reg <= hdr_needs_data;
         end
         if (cnt_reg == 6'h00 && serial_data_in) begin
            cmd_need_reg <= 1'b0;
         end
         if (full_hit) begin
            cmd_data_reg <= sh_next[15:0];
         end
      end
   end

   // Read pointer to memory word and byte lane; the top address bit is dropped.
   assign rd_idx = org_k2_reg ? rd_addr_reg[8:0] : rd_addr_reg[9:1];
   assign rd_wrap_mask = org_k2_reg ? `SEV_WORD_IDX_MASK : `SEV_BYTE_IDX_MASK;
   always_comb begin
      if (org_k2_reg) begin
         rd_sel = rd_data;
      end else if (rd_addr_reg[0]) begin
         rd_sel = {rd_data[7:0], 8'h00};
      end else begin
         rd_sel = {rd_data[15:8], 8'h00};
      end
   end

   // Read engine: dummy zero, then words back to back with auto increment.
   always_ff @(posedge serial_clock_in or posedge frame_clr) begin
      if (frame_clr) begin
         rd_active_reg <= 1'b0;
         rd_left_reg <= 5'h00;
         rd_word_reg <= 16'h0000;
         rd_addr_reg <= 10'h000;
         out_bit_reg <= 1'b0;
      end else if (hdr_hit && hdr_op == `SEV_OP_READ) begin
         rd_active_reg <= 1'b1;
         out_bit_reg <= 1'b0;
         rd_left_reg <= 5'h00;
         rd_addr_reg <= org_k2_reg ? {1'b0, hdr_addr[8:0]} : hdr_addr[9:0];
      end else if (rd_active_reg) begin
         if (rd_left_reg == 5'h00) begin
            // Next word follows without a separator bit.
            out_bit_reg <= rd_sel[15];
            rd_word_reg <= {rd_sel[14:0], 1'b0};
            rd_left_reg <= 5'(data_len - 6'h01);
            rd_addr_reg <= (rd_addr_reg + 10'h001) & rd_wrap_mask;
         end else begin
            out_bit_reg <= rd_word_reg[15];
            rd_word_reg <= {rd_word_reg[14:0], 1'b0};
            rd_left_reg <= rd_left_reg - 5'h01;
         end
      end
   end

   // A start bit seen during status releases the pin on the next falling edge.
   always_ff @(negedge serial_clock_in or posedge frame_clr) begin
      if (frame_clr) begin
         mute_reg <= 1'b0;
      end else if (cnt_reg != 6'h00) begin
         mute_reg <= 1'b1;
      end
   end

   // ---------------- System clock domain ----------------

   sev_state_t state_reg;
   logic cs_s1_reg;
   logic cs_s2_reg;
   logic cs_s3_reg;
   logic ok_s1_reg;
   logic ok_s2_reg;
   logic used_reg;
   logic org_s1_reg;
   logic org_s2_reg;
   logic cs_fall;
   logic go;
   logic [1:0] ext_sel;
   logic is_sweep;
   logic is_single;
   logic prog_ok;
   logic [9:0] byte_idx;
   logic [TW-1:0] timer_reg;
   logic [8:0] sweep_reg;
   logic [15:0] fill_reg;
   logic wen_reg;
   logic mem_we_reg;
   logic [8:0] mem_idx_reg;
   logic [15:0] mem_data_reg;
   logic [1:0] mem_mask_reg;
   logic armed_reg;
   logic status_oe_reg;
   logic status_val_reg;

   // Synchronisers for chip select, frame status and the strap.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cs_s1_reg <= 1'b0;
         cs_s2_reg <= 1'b0;
         cs_s3_reg <= 1'b0;
         ok_s1_reg <= 1'b0;
         ok_s2_reg <= 1'b0;
         org_s1_reg <= 1'b1;
         org_s2_reg <= 1'b1;
      end else begin
         cs_s1_reg <= chip_select;
         cs_s2_reg <= cs_s1_reg;
         cs_s3_reg <= cs_s2_reg;
         ok_s1_reg <= frame_ok_reg;
         ok_s2_reg <= ok_s1_reg;
         org_s1_reg <= word_org_sel;
         org_s2_reg <= org_s1_reg;
      end
   end

   // The command words are stable here: they last changed before select fell.
   assign cs_fall = cs_s3_reg & ~cs_s2_reg;
   assign go = cs_fall && ok_s2_reg && !used_reg && (state_reg == SEV_IDLE);
   assign ext_sel = org_s2_reg ? cmd_addr_reg[`SEV_W_EXT_HI:`SEV_W_EXT_LO] :
                                 cmd_addr_reg[`SEV_B_EXT_HI:`SEV_B_EXT_LO];
   assign is_sweep = (cmd_op_reg == `SEV_OP_EXT) &&
                     (ext_sel == `SEV_EXT_ERALL || ext_sel == `SEV_EXT_WRALL);
   assign is_single = (cmd_op_reg == `SEV_OP_WRITE) || (cmd_op_reg == `SEV_OP_ERASE);
   assign prog_ok = wen_reg && (is_sweep || is_single);
   assign byte_idx = cmd_addr_reg[9:0];

   // A finished frame starts one operation only; a later bare select must not repeat it.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         used_reg <= 1'b0;
      end else if (cs_fall || !ok_s2_reg) begin
         used_reg <= cs_fall && ok_s2_reg;
      end
   end

   // Write-enable latch: off at reset, changed only by the extended group.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wen_reg <= 1'b0;
      end else if (go && cmd_op_reg == `SEV_OP_EXT) begin
         if (ext_sel == `SEV_EXT_EN) begin
            wen_reg <= 1'b1;
         end else if (ext_sel == `SEV_EXT_DIS) begin
            wen_reg <= 1'b0;
         end
      end
   end

   // Programming engine: self-timed, needs no serial clock.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_reg <= SEV_IDLE;
         timer_reg <= '0;
         sweep_reg <= 9'h000;
         fill_reg <= `SEV_ONES;
      end else begin
         case (state_reg)
            SEV_IDLE: begin
               if (go && prog_ok) begin
                  timer_reg <= '0;
                  sweep_reg <= 9'h000;
                  if (ext_sel == `SEV_EXT_ERALL) begin
                     fill_reg <= `SEV_ONES;
                  end else if (org_s2_reg) begin
                     fill_reg <= cmd_data_reg;
                  end else begin
                     fill_reg <= {cmd_data_reg[7:0], cmd_data_reg[7:0]};
                  end
                  state_reg <= is_sweep ? SEV_SWEEP : SEV_WAIT;
               end
            end
            SEV_SWEEP: begin
               timer_reg <= timer_reg + TW'(1);
               sweep_reg <= sweep_reg + 9'h001;
               if (sweep_reg == `SEV_LAST_WORD) begin
                  state_reg <= SEV_WAIT;
               end
            end
            SEV_WAIT: begin
               timer_reg <= timer_reg + TW'(1);
               if (timer_reg == TW'(PROG_CYCLES - 1)) begin
                  state_reg <= SEV_IDLE;
               end
            end
            default: begin
               state_reg <= SEV_IDLE;
            end
         endcase
      end
   end

   // Memory write port: one masked write for single ops, a sweep for all.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         mem_we_reg <= 1'b0;
         mem_idx_reg <= 9'h000;
         mem_data_reg <= `SEV_ONES;
         mem_mask_reg <= 2'h0;
      end else if (state_reg == SEV_IDLE && go && prog_ok && is_single) begin
         mem_we_reg <= 1'b1;
         if (org_s2_reg) begin
            mem_idx_reg <= byte_idx[8:0];
            mem_mask_reg <= 2'h3;
         end else begin
            mem_idx_reg <= byte_idx[9:1];
            mem_mask_reg <= byte_idx[0] ? 2'h1 : 2'h2;
         end
         if (cmd_op_reg == `SEV_OP_ERASE) begin
            mem_data_reg <= `SEV_ONES;
         end else if (org_s2_reg) begin
            mem_data_reg <= cmd_data_reg;
         end else begin
            mem_data_reg <= {cmd_data_reg[7:0], cmd_data_reg[7:0]};
         end
      end else if (state_reg == SEV_SWEEP) begin
         mem_we_reg <= 1'b1;
         mem_idx_reg <= sweep_reg;
         mem_mask_reg <= 2'h3;
         mem_data_reg <= fill_reg;
      end else begin
         mem_we_reg <= 1'b0;
      end
   end

   // Busy status: armed when programming starts, shown while selected.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         armed_reg <= 1'b0;
         status_oe_reg <= 1'b0;
         status_val_reg <= 1'b1;
      end else begin
         if (go && prog_ok) begin
            armed_reg <= 1'b1;
         end else if (cs_fall && state_reg == SEV_IDLE) begin
            armed_reg <= 1'b0;
         end
         status_oe_reg <= armed_reg && cs_s2_reg;
         status_val_reg <= (state_reg == SEV_IDLE);
      end
   end

   // Storage array, written on the system clock and read by the link logic.
   sev_mem #(
      .WORDS(WORDS),
      .WIDTH(16)
   ) u_mem (
      .wr_clk(sys_clk),
      .wr_en(mem_we_reg),
      .wr_idx(mem_idx_reg),
      .wr_data(mem_data_reg),
      .wr_mask(mem_mask_reg),
      .rd_idx(rd_idx),
      .rd_data(rd_data)
   );

   // Pin drive: read data wins; status only while selected and not released.
   assign serial_data_out_en = rd_active_reg |
                               (status_oe_reg & ~mute_reg & chip_select);
   assign serial_data_out = rd_active_reg ? out_bit_reg : status_val_reg;

endmodule : sev_core

// *** design/sev_defs.svh ***
`ifndef SEV_DEFS_SVH
`define SEV_DEFS_SVH

// Opcode field values, start bit excluded.
`define SEV_OP_EXT 2'h0
`define SEV_OP_WRITE 2'h1
`define SEV_OP_READ 2'h2
`define SEV_OP_ERASE 2'h3

// Extended group selectors, the two top address bits.
`define SEV_EXT_DIS 2'h0
`define SEV_EXT_WRALL 2'h1
`define SEV_EXT_ERALL 2'h2
`define SEV_EXT_EN 2'h3

// Frame lengths without data, start bit included, and data lengths.
`define SEV_FRAME_WORD 6'h0d
`define SEV_FRAME_BYTE 6'h0e
`define SEV_DLEN_WORD 6'h10
`define SEV_DLEN_BYTE 6'h08

// Field positions in the shift register once the header is in.
`define SEV_W_OP_HI 11
`define SEV_W_OP_LO 10
`define SEV_W_ADDR_HI 9
`define SEV_B_OP_HI 12
`define SEV_B_OP_LO 11
`define SEV_B_ADDR_HI 10
`define SEV_W_EXT_HI 9
`define SEV_W_EXT_LO 8
`define SEV_B_EXT_HI 10
`define SEV_B_EXT_LO 9

// Address wrap masks for word and byte organisation.
`define SEV_WORD_IDX_MASK 10'h1ff
`define SEV_BYTE_IDX_MASK 10'h3ff
`define SEV_LAST_WORD 9'h1ff

// Cleared state of a location and byte lane width.
`define SEV_ONES 16'hffff
`define SEV_LANE_W 8

// Programming time and system clock rate.
`define SEV_PROG_TIME_MS 5
`define SEV_SYS_CLK_KHZ 25000

`endif

// *** design/sev_pkg.sv ***
package sev_pkg;

   // Programming engine states, one-hot.
   typedef enum logic [2:0] {
      SEV_IDLE = 3'b001,
      SEV_SWEEP = 3'b010,
      SEV_WAIT = 3'b100
   } sev_state_t;

endpackage : sev_pkg

// *** design/sev_mem.sv ***
`timescale 1ns/10ps
`include "sev_defs.svh"

module sev_mem #(
   parameter int WORDS = 512,
   parameter int WIDTH = 16
) (
   // Write port on the system clock.
   input wire logic wr_clk,
   input wire logic wr_en,
   input wire logic [$clog2(WORDS)-1:0] wr_idx,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [WIDTH/`SEV_LANE_W-1:0] wr_mask,
   // Asynchronous read port.
   input wire logic [$clog2(WORDS)-1:0] rd_idx,
   output logic [WIDTH-1:0] rd_data
);

   localparam int LANES = WIDTH / `SEV_LANE_W;

   // Refuses a width that does not split into whole byte lanes.
   if (WIDTH % `SEV_LANE_W != 0) begin : g_width_check
      $error("sev_mem width must be whole bytes");
   end

   // Each byte lane is its own array so a masked write touches one lane only.
   for (genvar l = 0; l < LANES; l++) begin : g_lane
      logic [`SEV_LANE_W-1:0] lane_q [WORDS];
      always_ff @(posedge wr_clk) begin
         if (wr_en && wr_mask[l]) begin
            lane_q[wr_idx] <= wr_data[l*`SEV_LANE_W +: `SEV_LANE_W];
         end
      end
      assign rd_data[l*`SEV_LANE_W +: `SEV_LANE_W] = lane_q[rd_idx];
   end

endmodule : sev_mem

// *** sim/sev_core_properties.sv ***
`timescale 1ns/10ps
`include "sev_defs.svh"
module sev_core_properties #(
   parameter int PROG_CYCLES = 125000
) (
   // Clocks, reset and strap.
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic word_org_sel,
   // Serial link.
   input wire logic serial_clock_in,
   input wire logic chip_select,
   input wire logic serial_data_in,
   input wire logic serial_data_out,
   input wire logic serial_data_out_en
);
   localparam int BUSY_LIMIT = PROG_CYCLES + 16;
   logic [5:0] bit_cnt_reg;
   logic [1:0] op_reg;
   logic release_reg;
   int busy_cnt_reg;

   // Counts bits from the start bit and keeps the opcode of the frame.
   always_ff @(posedge serial_clock_in or negedge chip_select) begin
      if (!chip_select) begin
         bit_cnt_reg <= 6'h00;
         op_reg <= 2'h0;
      end else begin
         if ((bit_cnt_reg != 6'h00 || serial_data_in) && bit_cnt_reg != 6'h3f) begin
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
         end
         if (bit_cnt_reg == 6'h01) begin
            op_reg[1] <= serial_data_in;
         end
         if (bit_cnt_reg == 6'h02) begin
            op_reg[0] <= serial_data_in;
         end
      end
   end

   // Marks a one clocked in while the output shows status.
   always_ff @(posedge serial_clock_in or negedge chip_select) begin
      if (!chip_select) begin
         release_reg <= 1'b0;
      end else begin
         release_reg <= bit_cnt_reg == 6'h00 && serial_data_in && serial_data_out_en;
      end
   end

   // Measures how long the busy status has been shown.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         busy_cnt_reg <= 0;
      end else if (chip_select && serial_data_out_en && !serial_data_out) begin
         busy_cnt_reg <= busy_cnt_reg + 1;
      end else begin
         busy_cnt_reg <= 0;
      end
   end

   sequence word_hdr_s;
      word_org_sel && bit_cnt_reg == `SEV_FRAME_WORD && op_reg == `SEV_OP_READ;
   endsequence
   sequence byte_hdr_s;
      !word_org_sel && bit_cnt_reg == `SEV_FRAME_BYTE && op_reg == `SEV_OP_READ;
   endsequence
   sequence read_body_s;
      chip_select && op_reg == `SEV_OP_READ && bit_cnt_reg != 6'h3f
         && bit_cnt_reg > (word_org_sel ? `SEV_FRAME_WORD : `SEV_FRAME_BYTE);
   endsequence

   unselected_quiet_a: assert property (@(posedge sys_clk) disable iff (reset)
      !chip_select |-> !serial_data_out_en) else $error("output driven while deselected");
   reset_quiet_a: assert property (@(posedge sys_clk)
      reset |-> !serial_data_out_en) else $error("output driven in reset");
   word_dummy_a: assert property (@(posedge serial_clock_in) disable iff (reset)
      word_hdr_s |-> serial_data_out_en && !serial_data_out) else $error("no word dummy zero");
   byte_dummy_a: assert property (@(posedge serial_clock_in) disable iff (reset)
      byte_hdr_s |-> serial_data_out_en && !serial_data_out) else $error("no byte dummy zero");
   read_stream_a: assert property (@(posedge serial_clock_in) disable iff (reset)
      read_body_s |-> serial_data_out_en) else $error("read stream interrupted");
   dummy_release_a: assert property (@(posedge sys_clk) disable iff (reset)
      release_reg && chip_select && !serial_clock_in |-> !serial_data_out_en)
      else $error("status not released");
   ready_holds_a: assert property (@(posedge sys_clk) disable iff (reset)
      chip_select && serial_data_out_en && serial_data_out && bit_cnt_reg == 6'h00
      |=> !serial_data_out_en || serial_data_out) else $error("ready went back to busy");
   busy_bound_a: assert property (@(posedge sys_clk) disable iff (reset)
      busy_cnt_reg < BUSY_LIMIT) else $error("busy too long");
endmodule : sev_core_properties

bind sev_core sev_core_properties #(.PROG_CYCLES(PROG_CYCLES)) u_sev_core_properties (
   .sys_clk(sys_clk), .reset(reset), .word_org_sel(word_org_sel),
   .serial_clock_in(serial_clock_in), .chip_select(chip_select),
   .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
   .serial_data_out_en(serial_data_out_en));

// *** sim/sev_host.sv ***
`timescale 1ns/10ps
module sev_host (
   // Alignment clock.
   input wire logic sys_clk,
   // Serial link.
   output logic serial_clock_in,
   output logic chip_select,
   output logic serial_data_in,
   input wire logic serial_data_out,
   input wire logic serial_data_out_en
);
   // The link clock rests low between frames.
   initial begin
      serial_clock_in = 1'b0;
      chip_select = 1'b0;
      serial_data_in = 1'b0;
   end

   // Waits out the start-up time before any command.
   task automatic power_wait;
      #1000000;
   endtask : power_wait

   // Shifts n bits MSB first, start bit and all address bits included.
   task automatic send(input logic [31:0] bits, input int n);
      @(posedge sys_clk);
      #1 chip_select = 1'b1;
      for (int i = n - 1; i >= 0; i--) begin
         serial_data_in = bits[i];
         #6 serial_clock_in = 1'b1;
         #6 serial_clock_in = 1'b0;
      end
   endtask : send

   // Deselects before the next rising edge, inverts the data line and waits six system clocks.
   task automatic drop;
      #1 chip_select = 1'b0;
      serial_data_in = ~serial_data_in;
      repeat (6) @(posedge sys_clk);
   endtask : drop

   // Reads the dummy bit and nb data bits; an undriven bit reads unknown.
   task automatic read(input logic [31:0] hdr, input int hn, input int nb,
         output logic [63:0] got);
      send(hdr, hn);
      got = {63'h0, serial_data_out_en ? serial_data_out : 1'bx};
      serial_data_in = 1'b0;
      for (int i = 0; i < nb; i++) begin
         #6 serial_clock_in = 1'b1;
         #6 serial_clock_in = 1'b0;
         got = {got[62:0], serial_data_out_en ? serial_data_out : 1'bx};
      end
      drop();
   endtask : read

   // Polls status, then releases the output with a dummy one.
   task automatic poll(input int limit, output logic busy, output logic ready,
         output logic rel_en);
      busy = 1'b0;
      ready = 1'b0;
      @(posedge sys_clk);
      #1 chip_select = 1'b1;
      for (int i = 0; i < limit && !ready; i++) begin
         @(posedge sys_clk);
         #1 busy = busy | (serial_data_out_en === 1'b1 && serial_data_out === 1'b0);
         ready = serial_data_out_en === 1'b1 && serial_data_out === 1'b1;
      end
      serial_data_in = 1'b1;
      #6 serial_clock_in = 1'b1;
      #6 serial_clock_in = 1'b0;
      @(posedge sys_clk);
      #1 rel_en = serial_data_out_en;
      drop();
   endtask : poll
endmodule : sev_host

// *** sim/serial_eeprom_command_interface_tb.sv ***
`timescale 1ns/10ps
`include "sev_defs.svh"
module serial_eeprom_command_interface_tb import sev_pkg::*;;
   logic sys_clk;
   logic reset;
   logic word_org_sel;
   logic serial_clock_in;
   logic chip_select;
   logic serial_data_in;
   logic serial_data_out;
   logic serial_data_out_en;
   logic b;
   logic r;
   logic e;
   logic [63:0] got;
   int mismatches;
   int checked;

   sev_core #(.PROG_CYCLES(600)) u_sev_core (
      .sys_clk(sys_clk), .reset(reset), .serial_clock_in(serial_clock_in),
      .chip_select(chip_select), .serial_data_in(serial_data_in),
      .word_org_sel(word_org_sel), .serial_data_out(serial_data_out),
      .serial_data_out_en(serial_data_out_en));
   sev_host u_sev_host (
      .sys_clk(sys_clk), .serial_clock_in(serial_clock_in), .chip_select(chip_select),
      .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
      .serial_data_out_en(serial_data_out_en));

   // System clock.
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report

   function automatic logic [31:0] cmd(input logic [1:0] op, input logic [9:0] a);
      cmd = {19'h0, 1'b1, op, a};
   endfunction : cmd

   function automatic logic [31:0] bcmd(input logic [1:0] op, input logic [10:0] a);
      bcmd = {18'h0, 1'b1, op, a};
   endfunction : bcmd

   // Programming frame that must show busy, then ready, then release.
   task automatic prog(input logic [31:0] bits, input int n);
      u_sev_host.send(bits, n);
      u_sev_host.drop();
      u_sev_host.poll(2000, b, r, e);
      check({61'h0, b, r, e}, 64'h6);
   endtask : prog

   // Frame that must not start a programming cycle.
   task automatic refused(input logic [31:0] bits, input int n);
      u_sev_host.send(bits, n);
      u_sev_host.drop();
      u_sev_host.poll(20, b, r, e);
      check({61'h0, b, r, e}, 64'h0);
   endtask : refused

   task automatic t_program;
      check({63'h0, serial_data_out_en}, 64'h0);
      refused((cmd(`SEV_OP_WRITE, 10'h005) << 16) | 32'h1234, 29);
      u_sev_host.send(cmd(`SEV_OP_EXT, {`SEV_EXT_EN, 8'h00}), 13);
      u_sev_host.drop();
      prog((cmd(`SEV_OP_EXT, {`SEV_EXT_WRALL, 8'h00}) << 16) | 32'ha5a5, 29);
      prog((cmd(`SEV_OP_WRITE, 10'h005) << 16) | 32'h1234, 29);
      prog((cmd(`SEV_OP_WRITE, 10'h006) << 16) | 32'hbeef, 29);
      prog(cmd(`SEV_OP_ERASE, 10'h006), 13);
      prog((cmd(`SEV_OP_WRITE, 10'h1ff) << 16) | 32'h0f0f, 29);
      refused(cmd(`SEV_OP_WRITE, 10'h005) >> 5, 8);
      refused((cmd(`SEV_OP_WRITE, 10'h005) << 17) | 32'haaaa, 30);
   endtask : t_program

   task automatic t_read;
      u_sev_host.read(cmd(`SEV_OP_READ, 10'h005), 13, 48, got);
      check(got, {15'h0, 1'b0, 16'h1234, 16'hffff, 16'ha5a5});
      u_sev_host.read(cmd(`SEV_OP_READ, 10'h3ff), 13, 32, got);
      check(got, {31'h0, 1'b0, 16'h0f0f, 16'ha5a5});
   endtask : t_read

   task automatic t_clear;
      prog(cmd(`SEV_OP_EXT, {`SEV_EXT_ERALL, 8'h00}), 13);
      u_sev_host.send(cmd(`SEV_OP_EXT, {`SEV_EXT_DIS, 8'h00}), 13);
      u_sev_host.drop();
      refused((cmd(`SEV_OP_WRITE, 10'h005) << 16), 29);
      u_sev_host.read(cmd(`SEV_OP_READ, 10'h004), 13, 32, got);
      check(got, {31'h0, 1'b0, 32'hffffffff});
   endtask : t_clear

   task automatic t_byte;
      @(posedge sys_clk);
      #1 word_org_sel = 1'b0;
      repeat (8) @(posedge sys_clk);
      u_sev_host.send(bcmd(`SEV_OP_EXT, {`SEV_EXT_EN, 9'h000}), 14);
      u_sev_host.drop();
      prog((bcmd(`SEV_OP_WRITE, 11'h00b) << 8) | 32'h3c, 22);
      u_sev_host.read(bcmd(`SEV_OP_READ, 11'h00a), 14, 16, got);
      check(got, {47'h0, 1'b0, 16'hff3c});
   endtask : t_byte

   // Main sequence.
   initial begin
      mismatches = 0;
      checked = 0;
      reset = 1'b1;
      word_org_sel = 1'b1;
      repeat (16) @(posedge sys_clk);
      #1 reset = 1'b0;
      u_sev_host.power_wait();
      t_program();
      t_read();
      t_clear();
      t_byte();
      final_report();
   end

   // Watchdog against a hung run.
   initial begin
      #3000000;
      mismatches++;
      final_report();
   end
endmodule : serial_eeprom_command_interface_tb
